// >>> opdec_map.vh
// Purpose: Shared constants for the string and branch opcode decoder.
// Assumes: Included by bare name from the opcode decoder design file only.
// Notes:   Definitions only; no logic lives here.
`ifndef OPDEC_MAP_VH
`define OPDEC_MAP_VH

// Decoder states.
`define ST_OP          2'h0
`define ST_MODRM       2'h1
`define ST_DISP        2'h2
`define ST_DATA        2'h3

// Instruction classes reported to the execution unit.
`define CLS_OTHER      4'h0
`define CLS_STRING     4'h1
`define CLS_COND       4'h2
`define CLS_LOOP       4'h3
`define CLS_CALL_NEAR  4'h4
`define CLS_CALL_FAR   4'h5
`define CLS_JUMP_NEAR  4'h6
`define CLS_JUMP_SHORT 4'h7
`define CLS_JUMP_FAR   4'h8
`define CLS_EXIT       4'h9
`define CLS_INT        4'hA
`define CLS_IRET       4'hB
`define CLS_CONTROL    4'hC
`define CLS_ESC        4'hD
`define CLS_IMMED      4'hE
`define CLS_GROUP2     4'hF

// First opcode bytes and patterns.
`define OPC_REPEAT     8'b1111001?
`define OPC_COND       8'h7?
`define OPC_LOOP       8'b111000??
`define OPC_LOOP_NZ    8'hE0
`define OPC_LOOPZ      8'hE1
`define OPC_LOOP_CNT   8'hE2
`define OPC_CNT_EMPTY  8'hE3
`define OPC_CALL_NEAR  8'hE8
`define OPC_CALL_FAR   8'h9A
`define OPC_JUMP_NEAR  8'hE9
`define OPC_JUMP_SHORT 8'hEB
`define OPC_JUMP_FAR   8'hEA
`define OPC_EXIT_PLAIN 8'b1100?011
`define OPC_EXIT_IMM   8'b1100?010
`define OPC_INT_TYPE   8'hCD
`define OPC_INT_3      8'hCC
`define OPC_INT_OVF    8'hCE
`define OPC_IRET       8'hCF
`define OPC_ESC        8'b11011???
`define OPC_STR_MOVE   8'b1010010?
`define OPC_STR_CMP    8'b1010011?
`define OPC_STR_STORE  8'b1010101?
`define OPC_STR_LOAD   8'b1010110?
`define OPC_STR_SCAN   8'b1010111?
`define OPC_IMMED      8'b100000??
`define OPC_GROUP2     8'b1111111?
`define OPC_LOCK       8'hF0
`define OPC_HALT       8'hF4
`define OPC_CMC        8'hF5
`define OPC_FLAGOP     8'b11111???
`define OPC_NOP        8'h90
`define OPC_WAIT       8'h9B
`define OPC_BLANK_0F   8'h0F
`define OPC_BLANK_6X   8'h6?
`define OPC_BLANK_C0   8'b1100?00?
`define OPC_BLANK_D6   8'hD6
`define OPC_BLANK_F1   8'hF1

// Field positions and codes.
`define W_BIT          0
`define SW_WORD_IMM    2'h1
`define SW_SEXT_IMM    2'h3
`define MOD_NO_DISP    2'h0
`define MOD_DISP8      2'h1
`define MOD_DISP16     2'h2
`define RM_DIRECT      3'h6
`define INT3_TYPE      8'h03
`define OVF_INT_TYPE   8'h04

`endif

// >>> branch_condition.v
// Purpose: Evaluates a conditional branch condition code against the flags.
// Assumes: Condition code is the low nibble of the branch opcode.
// Notes:   Purely combinational; the caller registers the result.
`timescale 1ns/1ns
`default_nettype none

module branch_condition (
  input  wire [3:0] cond_i,
  input  wire       zero_flag_i,
  input  wire       sign_flag_i,
  input  wire       overflow_flag_i,
  input  wire       carry_flag_i,
  input  wire       parity_flag_i,
  output reg        true_o
);

  reg base;

  // Even codes test the flag relation; odd codes are its complement.
  always @* begin
    base = 1'b0;
    case (cond_i[3:1])
      3'h0: base = overflow_flag_i;
      3'h1: base = carry_flag_i;
      3'h2: base = zero_flag_i;
      3'h3: base = carry_flag_i | zero_flag_i;
      3'h4: base = sign_flag_i;
      3'h5: base = parity_flag_i;
      3'h6: base = sign_flag_i ^ overflow_flag_i;
      3'h7: base = (sign_flag_i ^ overflow_flag_i) | zero_flag_i;
      default: base = 1'b0;
    endcase
    true_o = base ^ cond_i[0];
  end

endmodule

`default_nettype wire

// >>> opcode_decoder.v
// Purpose: Classifies first opcode bytes of the string, control-transfer and
//          processor-control families, gathers trailing bytes and evaluates
//          branch conditions.
// Assumes: One instruction byte per cycle when byte_valid_i is high; flags
//          and count status are valid in the cycle the last byte arrives.
// Notes:   Opcodes outside these families, other than the immediate and
//          group-two codes, are reported as single bytes of class other; their
//          trailing bytes must be consumed elsewhere.
`timescale 1ns/1ns
`default_nettype none
`include "opdec_map.vh"

module opcode_decoder (
  input  wire        core_clk_i,
  input  wire        rst_n_i,
  input  wire        byte_valid_i,
  input  wire [7:0]  byte_i,
  input  wire        zero_flag_i,
  input  wire        sign_flag_i,
  input  wire        overflow_flag_i,
  input  wire        carry_flag_i,
  input  wire        parity_flag_i,
  input  wire        count_zero_i,
  input  wire        count_one_i,
  output reg         insn_valid_o,
  output reg  [3:0]  insn_class_o,
  output reg  [7:0]  opcode_o,
  output reg  [7:0]  modrm_o,
  output reg         word_op_o,
  output reg         undefined_o,
  output reg  [15:0] operand_o,
  output reg  [15:0] segment_o,
  output reg  [15:0] ea_disp_o,
  output reg         branch_taken_o,
  output reg         repeat_o,
  output reg         repeat_continue_o,
  output reg  [15:0] stack_adjust_o,
  output reg         exit_far_o,
  output reg         int_request_o,
  output reg  [7:0]  int_type_o,
  output reg         esc_valid_o,
  output reg  [2:0]  esc_code_o
);

  reg  [1:0]  st_ff;
  reg  [7:0]  op_ff;
  reg  [7:0]  modrm_ff;
  reg  [31:0] data_ff;
  reg  [15:0] disp_ff;
  reg  [1:0]  idx_ff;
  reg  [2:0]  left_ff;
  reg  [1:0]  disp_left_ff;
  reg  [1:0]  imm_n_ff;
  reg         rpt_pend_ff;
  reg         rpt_match_ff;

  reg  [7:0]  f_op;
  reg  [7:0]  f_modrm;
  reg  [31:0] f_data;
  reg  [15:0] f_disp;
  reg  [3:0]  d_cls;
  reg  [2:0]  d_tail;
  reg         d_modrm;
  reg  [1:0]  d_imm;
  reg         d_undef;
  reg  [1:0]  m_disp;
  reg         fin;
  reg         is_rpt;
  reg         loop_take;
  reg  [15:0] sext8;
  wire        cond_true;

  // Final view of the instruction including the byte arriving this cycle.
  always @* begin
    f_op    = (st_ff == `ST_OP) ? byte_i : op_ff;
    f_modrm = (st_ff == `ST_MODRM) ? byte_i : modrm_ff;
    f_data  = data_ff;
    f_disp  = disp_ff;
    if (st_ff == `ST_DATA) begin
      case (idx_ff)
        2'h0: f_data[7:0]   = byte_i;
        2'h1: f_data[15:8]  = byte_i;
        2'h2: f_data[23:16] = byte_i;
        default: f_data[31:24] = byte_i;
      endcase
    end
    if (st_ff == `ST_DISP) begin
      if (idx_ff == 2'h0) begin
        f_disp[7:0] = byte_i;
        f_disp[15:8] = {8{byte_i[7]}};
      end else begin
        f_disp[15:8] = byte_i;
      end
    end
    sext8 = {{8{f_data[7]}}, f_data[7:0]};
  end

  // Opcode classification with trailing byte counts.
  always @* begin
    d_cls   = `CLS_OTHER;
    d_tail  = 3'h0;
    d_modrm = 1'b0;
    d_imm   = 2'h0;
    d_undef = 1'b0;
    casez (f_op)
      `OPC_COND: begin
        d_cls  = `CLS_COND;
        d_tail = 3'h1;
      end
      `OPC_LOOP: begin
        d_cls  = `CLS_LOOP;
        d_tail = 3'h1;
      end
      `OPC_CALL_NEAR: begin
        d_cls  = `CLS_CALL_NEAR;
        d_tail = 3'h2;
      end
      `OPC_CALL_FAR: begin
        d_cls  = `CLS_CALL_FAR;
        d_tail = 3'h4;
      end
      `OPC_JUMP_NEAR: begin
        d_cls  = `CLS_JUMP_NEAR;
        d_tail = 3'h2;
      end
      `OPC_JUMP_SHORT: begin
        d_cls  = `CLS_JUMP_SHORT;
        d_tail = 3'h1;
      end
      `OPC_JUMP_FAR: begin
        d_cls  = `CLS_JUMP_FAR;
        d_tail = 3'h4;
      end
      `OPC_EXIT_PLAIN: d_cls = `CLS_EXIT;
      `OPC_EXIT_IMM: begin
        d_cls  = `CLS_EXIT;
        d_tail = 3'h2;
      end
      `OPC_INT_TYPE: begin
        d_cls  = `CLS_INT;
        d_tail = 3'h1;
      end
      `OPC_INT_3, `OPC_INT_OVF: d_cls = `CLS_INT;
      `OPC_IRET: d_cls = `CLS_IRET;
      `OPC_ESC: begin
        d_cls   = `CLS_ESC;
        d_modrm = 1'b1;
      end
      `OPC_STR_MOVE, `OPC_STR_CMP, `OPC_STR_STORE, `OPC_STR_LOAD, `OPC_STR_SCAN:
        d_cls = `CLS_STRING;
      `OPC_IMMED: begin
        d_cls   = `CLS_IMMED;
        d_modrm = 1'b1;
        d_imm   = (f_op[1:0] == `SW_WORD_IMM) ? 2'h2 : 2'h1;
      end
      `OPC_GROUP2: begin
        d_cls   = `CLS_GROUP2;
        d_modrm = 1'b1;
      end
      `OPC_LOCK, `OPC_HALT, `OPC_CMC, `OPC_NOP, `OPC_WAIT:
        d_cls = `CLS_CONTROL;
      `OPC_BLANK_0F, `OPC_BLANK_6X, `OPC_BLANK_C0, `OPC_BLANK_D6, `OPC_BLANK_F1:
        d_undef = 1'b1;
      default: begin
        // The flag-operation row shares its pattern with the group-two codes.
        if (f_op[7:3] == 5'h1F && f_op[2:1] != 2'h3) begin
          d_cls = `CLS_CONTROL;
        end else begin
          d_cls = `CLS_OTHER;
        end
      end
    endcase
  end

  // Displacement bytes implied by the mode/register/memory byte.
  always @* begin
    case (f_modrm[7:6])
      `MOD_NO_DISP: m_disp = (f_modrm[2:0] == `RM_DIRECT) ? 2'h2 : 2'h0;
      `MOD_DISP8:   m_disp = 2'h1;
      `MOD_DISP16:  m_disp = 2'h2;
      default:      m_disp = 2'h0;
    endcase
  end

  // Completion and loop decisions for the byte in hand.
  always @* begin
    is_rpt = (st_ff == `ST_OP) && (byte_i[7:1] == 7'h79);
    fin = 1'b0;
    if (byte_valid_i) begin
      case (st_ff)
        `ST_OP:    fin = !is_rpt && !d_modrm && (d_tail == 3'h0);
        `ST_MODRM: fin = (m_disp == 2'h0) && (imm_n_ff == 2'h0);
        `ST_DISP:  fin = (disp_left_ff == 2'h1) && (imm_n_ff == 2'h0);
        `ST_DATA:  fin = (left_ff == 3'h1);
        default:   fin = 1'b0;
      endcase
    end
    case (f_op)
      `OPC_LOOP_NZ:   loop_take = !count_one_i && !zero_flag_i;
      `OPC_LOOPZ:     loop_take = !count_one_i && zero_flag_i;
      `OPC_LOOP_CNT:  loop_take = !count_one_i;
      `OPC_CNT_EMPTY: loop_take = count_zero_i;
      default:        loop_take = 1'b0;
    endcase
  end

  branch_condition u_cond (
    .cond_i          (f_op[3:0]),
    .zero_flag_i     (zero_flag_i),
    .sign_flag_i     (sign_flag_i),
    .overflow_flag_i (overflow_flag_i),
    .carry_flag_i    (carry_flag_i),
    .parity_flag_i   (parity_flag_i),
    .true_o          (cond_true)
  );

  // Byte gathering state machine; a prefix keeps it waiting for an opcode.
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff        <= `ST_OP;
      op_ff        <= 8'h00;
      modrm_ff     <= 8'h00;
      data_ff      <= 32'h0000_0000;
      disp_ff      <= 16'h0000;
      idx_ff       <= 2'h0;
      left_ff      <= 3'h0;
      disp_left_ff <= 2'h0;
      imm_n_ff     <= 2'h0;
      rpt_pend_ff  <= 1'b0;
      rpt_match_ff <= 1'b0;
    end else if (byte_valid_i) begin
      data_ff <= f_data;
      disp_ff <= f_disp;
      case (st_ff)
        `ST_OP: begin
          if (is_rpt) begin
            rpt_pend_ff  <= 1'b1;
            rpt_match_ff <= byte_i[0];
          end else begin
            op_ff    <= byte_i;
            imm_n_ff <= d_imm;
            idx_ff   <= 2'h0;
            data_ff  <= 32'h0000_0000;
            disp_ff  <= 16'h0000;
            if (d_modrm) begin
              st_ff <= `ST_MODRM;
            end else if (d_tail != 3'h0) begin
              st_ff   <= `ST_DATA;
              left_ff <= d_tail;
            end
          end
        end
        `ST_MODRM: begin
          modrm_ff <= byte_i;
          if (m_disp != 2'h0) begin
            st_ff        <= `ST_DISP;
            disp_left_ff <= m_disp;
          end else if (imm_n_ff != 2'h0) begin
            st_ff   <= `ST_DATA;
            left_ff <= {1'b0, imm_n_ff};
          end else begin
            st_ff <= `ST_OP;
          end
        end
        `ST_DISP: begin
          disp_left_ff <= disp_left_ff - 2'h1;
          idx_ff       <= idx_ff + 2'h1;
          if (disp_left_ff == 2'h1) begin
            idx_ff <= 2'h0;
            if (imm_n_ff != 2'h0) begin
              st_ff   <= `ST_DATA;
              left_ff <= {1'b0, imm_n_ff};
            end else begin
              st_ff <= `ST_OP;
            end
          end
        end
        `ST_DATA: begin
          left_ff <= left_ff - 3'h1;
          idx_ff  <= idx_ff + 2'h1;
          if (left_ff == 3'h1) begin
            st_ff <= `ST_OP;
          end
        end
        default: st_ff <= `ST_OP;
      endcase
      // A lock prefix passes a pending repeat on to the next opcode.
      if (fin && f_op != `OPC_LOCK) begin
        rpt_pend_ff <= 1'b0;
      end
    end
  end

  // Result registers; the strobes are one-cycle pulses, fields hold.
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      insn_valid_o      <= 1'b0;
      insn_class_o      <= `CLS_OTHER;
      opcode_o          <= 8'h00;
      modrm_o           <= 8'h00;
      word_op_o         <= 1'b0;
      undefined_o       <= 1'b0;
      operand_o         <= 16'h0000;
      segment_o         <= 16'h0000;
      ea_disp_o         <= 16'h0000;
      branch_taken_o    <= 1'b0;
      repeat_o          <= 1'b0;
      repeat_continue_o <= 1'b0;
      stack_adjust_o    <= 16'h0000;
      exit_far_o        <= 1'b0;
      int_request_o     <= 1'b0;
      int_type_o        <= 8'h00;
      esc_valid_o       <= 1'b0;
      esc_code_o        <= 3'h0;
    end else begin
      insn_valid_o  <= fin;
      int_request_o <= 1'b0;
      esc_valid_o   <= 1'b0;
      if (fin) begin
        insn_class_o <= d_cls;
        opcode_o     <= f_op;
        modrm_o      <= d_modrm ? f_modrm : 8'h00;
        word_op_o    <= f_op[`W_BIT];
        undefined_o  <= d_undef;
        ea_disp_o    <= d_modrm ? f_disp : 16'h0000;
        segment_o    <= f_data[31:16];
        // Short displacements and the sign-extended immediate widen here.
        case (d_cls)
          `CLS_COND, `CLS_LOOP, `CLS_JUMP_SHORT: operand_o <= sext8;
          `CLS_IMMED: begin
            if (f_op[1:0] == `SW_SEXT_IMM) begin
              operand_o <= sext8;
            end else if (f_op[1:0] == `SW_WORD_IMM) begin
              operand_o <= f_data[15:0];
            end else begin
              operand_o <= {8'h00, f_data[7:0]};
            end
          end
          `CLS_INT: operand_o <= {8'h00, f_data[7:0]};
          default:  operand_o <= f_data[15:0];
        endcase
        case (d_cls)
          `CLS_COND: branch_taken_o <= cond_true;
          `CLS_LOOP: branch_taken_o <= loop_take;
          `CLS_CALL_NEAR, `CLS_CALL_FAR, `CLS_JUMP_NEAR, `CLS_JUMP_SHORT, `CLS_JUMP_FAR,
          `CLS_EXIT, `CLS_IRET: branch_taken_o <= 1'b1;
          default: branch_taken_o <= 1'b0;
        endcase
        // Move, load and store repeat on count alone; compare and scan also on zero.
        repeat_o          <= rpt_pend_ff && (d_cls == `CLS_STRING);
        repeat_continue_o <= rpt_pend_ff && (d_cls == `CLS_STRING) &&
                             ((f_op[3:1] != 3'h3 && f_op[3:1] != 3'h7) ||
                              (zero_flag_i == rpt_match_ff));
        stack_adjust_o <= (d_cls == `CLS_EXIT && !f_op[0]) ? f_data[15:0] : 16'h0000;
        exit_far_o     <= (d_cls == `CLS_EXIT) && f_op[3];
        if (f_op == `OPC_INT_TYPE) begin
          int_request_o <= 1'b1;
          int_type_o    <= f_data[7:0];
        end else if (f_op == `OPC_INT_3) begin
          int_request_o <= 1'b1;
          int_type_o    <= `INT3_TYPE;
        end else if (f_op == `OPC_INT_OVF) begin
          int_request_o <= overflow_flag_i;
          int_type_o    <= `OVF_INT_TYPE;
        end
        if (d_cls == `CLS_ESC) begin
          esc_valid_o <= 1'b1;
          esc_code_o  <= f_op[2:0];
        end
      end
    end
  end

endmodule

`default_nettype wire

// >>> opcode_decoder_checker.sv
// Purpose: Port-level assertions for the opcode decoder.
// Assumes: Flags and count status are sampled with the last instruction byte.
// Notes:   Flag-dependent checks look one cycle back, where that byte was taken.
`timescale 1ns/1ns
`default_nettype none

module opcode_decoder_checker (
  input wire logic        core_clk_i,
  input wire logic        rst_n_i,
  input wire logic        byte_valid_i,
  input wire logic        zero_flag_i,
  input wire logic        sign_flag_i,
  input wire logic        overflow_flag_i,
  input wire logic        carry_flag_i,
  input wire logic        parity_flag_i,
  input wire logic        count_zero_i,
  input wire logic        insn_valid_o,
  input wire logic [3:0]  insn_class_o,
  input wire logic [7:0]  opcode_o,
  input wire logic        word_op_o,
  input wire logic        undefined_o,
  input wire logic [15:0] operand_o,
  input wire logic        branch_taken_o,
  input wire logic        repeat_o,
  input wire logic        repeat_continue_o,
  input wire logic [15:0] stack_adjust_o,
  input wire logic        exit_far_o,
  input wire logic        int_request_o,
  input wire logic [7:0]  int_type_o,
  input wire logic        esc_valid_o,
  input wire logic [2:0]  esc_code_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  // Condition table kept apart from the design so a shared slip cannot hide.
  function automatic logic cond_true(input logic [3:0] c, input logic z, s, o, cy, p);
    logic r;
    case (c[3:1])
      3'h0: r = o;
      3'h1: r = cy;
      3'h2: r = z;
      3'h3: r = cy | z;
      3'h4: r = s;
      3'h5: r = p;
      3'h6: r = s ^ o;
      default: r = (s ^ o) | z;
    endcase
    return r ^ c[0];
  endfunction

  // Every rule except the first half of chk_repeat_cont is tied to the completion pulse and the instruction it reports.
  chk_cond_eval: assert property (insn_valid_o && insn_class_o == 4'h2 |->
    branch_taken_o == cond_true(opcode_o[3:0], $past(zero_flag_i), $past(sign_flag_i),
    $past(overflow_flag_i), $past(carry_flag_i), $past(parity_flag_i))) else $error("bad cond");
  chk_cond_class: assert property (insn_valid_o && opcode_o[7:4] == 4'h7 |->
    insn_class_o == 4'h2 && $past(byte_valid_i)) else $error("bad cond class");
  chk_width_bit: assert property (insn_valid_o && insn_class_o inside {4'h1, 4'hE} |->
    word_op_o == opcode_o[0]) else $error("bad width");
  chk_sext_imm: assert property (insn_valid_o && opcode_o == 8'h83 |->
    operand_o[15:8] == {8{operand_o[7]}}) else $error("bad sign extension");
  chk_repeat_cont: assert property ((repeat_continue_o |-> repeat_o) and
    (insn_valid_o && repeat_o && opcode_o[2:1] != 2'h3 |-> repeat_continue_o))
    else $error("bad repeat");
  chk_int_ovf: assert property (insn_valid_o && opcode_o == 8'hCE |->
    int_request_o == $past(overflow_flag_i) && int_type_o == 8'h04) else $error("bad int");
  chk_int_pulse: assert property (int_request_o |-> insn_valid_o && insn_class_o == 4'hA)
    else $error("stray int");
  chk_esc_code: assert property (esc_valid_o |-> insn_valid_o && opcode_o[7:3] == 5'h1B &&
    esc_code_o == opcode_o[2:0] && insn_class_o == 4'hD) else $error("bad escape");
  chk_exit_adjust: assert property (insn_valid_o && insn_class_o == 4'h9 && opcode_o[0] |->
    stack_adjust_o == 16'h0000 && exit_far_o == opcode_o[3]) else $error("bad return");
  chk_undef_class: assert property (insn_valid_o && undefined_o |->
    insn_class_o == 4'h0 && !branch_taken_o) else $error("bad undefined");
  chk_loop_count: assert property (insn_valid_o && opcode_o == 8'hE3 |->
    branch_taken_o == $past(count_zero_i)) else $error("bad count branch");

  cov_cond_taken: cover property (insn_valid_o && insn_class_o == 4'h2 && branch_taken_o);
  cov_escape: cover property (esc_valid_o);
  cov_int: cover property (int_request_o);
  cov_repeat: cover property (insn_valid_o && repeat_o && !repeat_continue_o);
endmodule

bind opcode_decoder opcode_decoder_checker chk (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .byte_valid_i(byte_valid_i),
  .zero_flag_i(zero_flag_i), .sign_flag_i(sign_flag_i), .overflow_flag_i(overflow_flag_i),
  .carry_flag_i(carry_flag_i), .parity_flag_i(parity_flag_i), .count_zero_i(count_zero_i),
  .insn_valid_o(insn_valid_o), .insn_class_o(insn_class_o), .opcode_o(opcode_o),
  .word_op_o(word_op_o), .undefined_o(undefined_o), .operand_o(operand_o),
  .branch_taken_o(branch_taken_o), .repeat_o(repeat_o), .repeat_continue_o(repeat_continue_o),
  .stack_adjust_o(stack_adjust_o), .exit_far_o(exit_far_o), .int_request_o(int_request_o),
  .int_type_o(int_type_o), .esc_valid_o(esc_valid_o), .esc_code_o(esc_code_o));
`default_nettype wire

// >>> fetch_source.sv
// Purpose: Instruction byte stream source standing in for the fetch logic.
// Assumes: Bytes change only at the falling clock edge.
// Notes:   Idle cycles toggle the byte lines so a stale byte is never mistaken.
`timescale 1ns/1ns
`default_nettype none

module fetch_source (
  input  wire logic       core_clk_i,
  output var  logic       byte_valid_o,
  output var  logic [7:0] byte_o
);
  initial begin
    byte_valid_o = 1'b0;
    byte_o = 8'hA5;
  end

  // One idle cycle; the data lines show the inverse of the last value.
  task automatic idle();
    @(negedge core_clk_i);
    byte_valid_o = 1'b0;
    byte_o = ~byte_o;
  endtask

  // Presents one byte after an optional stall, as a slow fetch would.
  task automatic put(input logic [7:0] b, input int gap);
    repeat (gap) idle();
    @(negedge core_clk_i);
    byte_valid_o = 1'b1;
    byte_o = b;
  endtask
endmodule
`default_nettype wire

// >>> tb_opcode_decoder.sv
// Purpose: Self-checking bench for the opcode decoder against a queue-based model.
// Assumes: Flags and count status are held steady across each instruction.
// Notes:   An idle cycle follows each instruction so every completion is seen alone.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin failures++; \
  $display("FAIL t=%0t got=%0h exp=%0h", $time, (a), (b)); end end

module tb_opcode_decoder;
  logic        core_clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        byte_valid_i;
  logic [7:0]  byte_i;
  logic [4:0]  flg = 5'h00;
  logic [1:0]  cnt = 2'h0;
  logic        insn_valid_o, word_op_o, undefined_o, branch_taken_o, repeat_o;
  logic        repeat_continue_o, exit_far_o, int_request_o, esc_valid_o;
  logic [3:0]  insn_class_o;
  logic [7:0]  opcode_o, modrm_o, int_type_o;
  logic [15:0] operand_o, segment_o, ea_disp_o, stack_adjust_o;
  logic [2:0]  esc_code_o;
  int          failures = 0;
  int          num_checks = 0;
  int          i;
  int          n;
  logic [7:0]  sl[10] = '{8'hA4, 8'hA5, 8'hA6, 8'hA7, 8'hAA, 8'hAB, 8'hAC, 8'hAD, 8'hAE, 8'hAF};
  logic [7:0]  ul[15] = '{8'h0F, 8'h60, 8'h6F, 8'hC0, 8'hC1, 8'hC8, 8'hC9, 8'hD6, 8'hF1,
                          8'hCF, 8'hF0, 8'hF4, 8'h90, 8'h9B, 8'hFA};

  always #20 core_clk_i = ~core_clk_i;

  fetch_source src (.core_clk_i(core_clk_i), .byte_valid_o(byte_valid_i), .byte_o(byte_i));

  opcode_decoder dut (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .byte_valid_i(byte_valid_i), .byte_i(byte_i),
    .zero_flag_i(flg[0]), .sign_flag_i(flg[1]), .overflow_flag_i(flg[2]),
    .carry_flag_i(flg[3]), .parity_flag_i(flg[4]), .count_zero_i(cnt[0]),
    .count_one_i(cnt[1]), .insn_valid_o(insn_valid_o), .insn_class_o(insn_class_o),
    .opcode_o(opcode_o), .modrm_o(modrm_o), .word_op_o(word_op_o), .undefined_o(undefined_o),
    .operand_o(operand_o), .segment_o(segment_o), .ea_disp_o(ea_disp_o),
    .branch_taken_o(branch_taken_o), .repeat_o(repeat_o), .exit_far_o(exit_far_o),
    .repeat_continue_o(repeat_continue_o), .stack_adjust_o(stack_adjust_o),
    .int_request_o(int_request_o), .int_type_o(int_type_o), .esc_valid_o(esc_valid_o),
    .esc_code_o(esc_code_o));

  function automatic logic [7:0] rb();
    return 8'($urandom);
  endfunction

  function automatic logic [15:0] sx(input logic [7:0] b);
    return {{8{b[7]}}, b};
  endfunction

  // Condition reference built from the flag table, not from the design.
  function automatic logic cond_ref(input logic [3:0] c);
    logic [7:0] t;
    t = {(flg[1] ^ flg[2]) | flg[0], flg[1] ^ flg[2], flg[4], flg[1],
         flg[3] | flg[0], flg[0], flg[3], flg[2]};
    return t[c[3:1]] ^ c[0];
  endfunction

  // Sends one instruction with random stalls, then compares the model with the outputs.
  task automatic run(input logic [7:0] q[$]);
    int k, j, dl;
    logic [7:0] op;
    logic [3:0] cls;
    logic [15:0] opd, seg, ed;
    logic tk, ir, rp, rc, und;
    k = (q[0][7:1] == 7'h79) ? 1 : 0;
    op = q[k];
    rp = (k == 1);
    rc = rp && (op[2:1] != 2'h3 || flg[0] == q[0][0]);
    {cls, opd, seg, ed, tk, ir, und} = '0;
    casez (op)
      8'h7?: {cls, opd, tk} = {4'h2, sx(q[k+1]), cond_ref(op[3:0])};
      8'b111000??: {cls, opd, tk} = {4'h3, sx(q[k+1]), (op[1:0] == 2'h3) ? cnt[0] :
                                     !cnt[1] && (op[1] || op[0] == flg[0])};
      8'hE8, 8'hE9: {cls, opd, tk} = {op[0] ? 4'h6 : 4'h4, q[k+2], q[k+1], 1'b1};
      8'hEB: {cls, opd, tk} = {4'h7, sx(q[k+1]), 1'b1};
      8'h9A, 8'hEA: {cls, opd, seg, tk} = {op[4] ? 4'h5 : 4'h8, q[k+2], q[k+1], q[k+4], q[k+3], 1'b1};
      8'b1100?01?: {cls, opd} = {4'h9, op[0] ? 16'h0000 : {q[k+2], q[k+1]}};
      8'hCC, 8'hCD, 8'hCE: {cls, ir, opd} = {4'hA, op[1] ? flg[2] : 1'b1, 8'h00, q[k+1]};
      8'b11011???: cls = 4'hD;
      8'b100000??, 8'b1111111?: begin
        dl = (q[k+1][7:6] == 2'h1) ? 1 : (q[k+1][7:6] == 2'h2 ||
             (q[k+1][7:6] == 2'h0 && q[k+1][2:0] == 3'h6)) ? 2 : 0;
        j = k + 2 + dl;
        cls = op[6] ? 4'hF : 4'hE;
        ed = (dl == 2) ? {q[k+3], q[k+2]} : (dl == 1) ? sx(q[k+2]) : 16'h0000;
        if (!op[6])
          opd = (op[1:0] == 2'h1) ? {q[j+1], q[j]} : (op[1:0] == 2'h3) ? sx(q[j]) : {8'h00, q[j]};
      end
      8'hCF: cls = 4'hB;
      8'hF0, 8'hF4, 8'hF5, 8'h90, 8'h9B, 8'b11111???: cls = 4'hC;
      8'b101001??, 8'b1010101?, 8'b101011??: cls = 4'h1;
      8'h0F, 8'h6?, 8'b1100?00?, 8'hD6, 8'hF1: und = 1'b1;
      default: cls = 4'h0;
    endcase
    foreach (q[m]) src.put(q[m], $urandom % 2);
    src.idle();
    for (j = 0; j < 3 && insn_valid_o !== 1'b1; j++) @(negedge core_clk_i);
    `CHK(insn_valid_o, 1'b1)
    `CHK(insn_class_o, cls)
    `CHK(undefined_o, und)
    `CHK(int_request_o, ir)
    `CHK(esc_valid_o, op[7:3] == 5'h1B)
    if (cls inside {4'h1, 4'hE}) `CHK(word_op_o, op[0])
    if (cls == 4'h1) `CHK({repeat_o, repeat_continue_o}, {rp, rc})
    if (cls inside {[4'h2:4'h8], 4'hE} || op == 8'hCD) `CHK(operand_o, opd)
    if (cls inside {[4'h2:4'h8]}) `CHK(branch_taken_o, tk)
    if (cls == 4'h5 || cls == 4'h8) `CHK({operand_o, segment_o}, {opd, seg})
    if (cls == 4'h9) `CHK({stack_adjust_o, exit_far_o}, {opd, op[3]})
    if (cls inside {4'hD, 4'hE, 4'hF}) `CHK({modrm_o, ea_disp_o}, {q[k+1], ed})
    if (cls == 4'hA) `CHK(int_type_o, op[1] ? 8'h04 : op[0] ? q[k+1] : 8'h03)
  endtask

  task automatic print_verdict();
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Watchdog at 8000 cycles, well beyond the few hundred cycles the sequence needs.
  initial begin
    #(40 * 8000);
    failures++;
    print_verdict();
  end

  // Main sequence: reset, then each opcode family with random operands and flags.
  initial begin
    void'($urandom(32'h0CED));
    repeat (20) @(posedge core_clk_i);
    @(negedge core_clk_i) rst_n_i = 1'b1;
    for (i = 0; i < 32; i++) begin
      flg = 5'($urandom);
      run('{{4'h7, i[3:0]}, rb()});
    end
    for (i = 0; i < 16; i++) begin
      flg = 5'($urandom);
      n = $urandom % 3;
      cnt = {n == 1, n == 0};
      run('{{6'h38, i[1:0]}, rb()});
    end
    run('{8'hE8, rb(), rb()});
    run('{8'hE9, rb(), rb()});
    run('{8'hEB, 8'h80});
    run('{8'h9A, rb(), rb(), rb(), rb()});
    run('{8'hEA, rb(), rb(), rb(), rb()});
    run('{8'hC2, rb(), rb()});
    run('{8'hCA, 8'hFF, 8'hFF});
    run('{8'hC3});
    run('{8'hCB});
    run('{8'hCD, rb()});
    run('{8'hCC});
    for (i = 0; i < 2; i++) begin
      flg = {2'h0, i[0], 2'h0};
      run('{8'hCE});
    end
    for (i = 0; i < 8; i++) run('{{5'h1B, i[2:0]}, {2'h3, 6'($urandom)}});
    run('{8'h83, 8'h41, rb(), 8'hF0});
    run('{8'h83, 8'hC0, 8'h7F});
    run('{8'h81, 8'hC3, rb(), rb()});
    run('{8'h81, 8'h86, rb(), rb(), rb(), rb()});
    run('{8'h80, 8'h06, rb(), rb(), 8'hFE});
    run('{8'h82, 8'hD1, 8'h9C});
    run('{8'hFF, 8'h56, rb()});
    run('{8'hFE, 8'h80, rb(), rb()});
    for (i = 0; i < 20; i++) begin
      flg = 5'($urandom);
      run('{{7'h79, i[0]}, sl[i % 10]});
    end
    foreach (ul[m]) run('{ul[m]});
    // A second reset in mid-run must clear the reported class.
    @(negedge core_clk_i) rst_n_i = 1'b0;
    @(negedge core_clk_i) rst_n_i = 1'b1;
    `CHK(insn_class_o, 4'h0)
    run('{8'h74, rb()});
    print_verdict();
  end
endmodule
`undef CHK
`default_nettype wire
